// [core/pxm_pkg.sv]
// Purpose: shared constants for the event mask, command monitor and port map
// Assumes: one clock, mclk at 100 MHz; asynchronous active-high reset
// Notes: offsets are byte addresses within the controller register space
`default_nettype none
package pxm_pkg;
   localparam int ADDR_W = 16;
   localparam int DATA_W = 32;
   localparam int NPORT = 3;

   // register offsets
   localparam logic [15:0] OFF_STATUS = 16'hd094;
   localparam logic [15:0] OFF_IRQ_EN = 16'hd098;
   localparam logic [15:0] OFF_TGT_CMD = 16'hd09c;
   localparam logic [15:0] OFF_PORT_MAP = 16'hd100;

   // event and enable bit positions (status and mask share them)
   localparam int BIT_PSTATE = 24;
   localparam int BIT_WAKE_SET = 23;
   localparam int BIT_WAKE_CLR = 22;
   localparam int BIT_FAST = 21;
   localparam int EV_LO = 21;
   localparam int EV_HI = 24;

   // command monitor field
   localparam int CMD_LO = 0;
   localparam int CMD_W = 4;

   // port map field positions: A, B, C
   localparam int PORT_A_LO = 28;
   localparam int PORT_B_LO = 24;
   localparam int PORT_C_LO = 20;
   localparam int SEL_W = 3;

   // reset values
   localparam logic [3:0] RST_IRQ_EN = 4'h0;
   localparam logic [2:0] RST_FLAGS = 3'h0;
   localparam logic [3:0] RST_CMD = 4'h0;
   localparam logic [2:0] RST_PORT_A = 3'h7;
   localparam logic [2:0] RST_PORT_B = 3'h6;
   localparam logic [2:0] RST_PORT_C = 3'h5;

   // source codes; 3'h4 to 3'h6 are reserved
   localparam logic [2:0] SRC_CTRL = 3'h7;
   localparam logic [2:0] SRC_RSV_LO = 3'h4;
endpackage
`default_nettype wire

// [core/pxm_if.sv]
// Purpose: joins the register group and its far party
// Assumes: both ends on mclk; request lines are active-low pins
// Notes: reg_req is a one-cycle pulse, reg_ack follows one cycle later
`default_nettype none
interface pxm_if;
   import pxm_pkg::*;
   // register access
   logic reg_req;
   logic reg_we;
   logic [ADDR_W-1:0] reg_addr;
   logic [DATA_W-1:0] reg_wdata;
   logic [DATA_W-1:0] reg_rdata;
   logic reg_ack;
   // power management configuration events
   logic pm_state_wr;
   logic pme_en_set;
   logic pme_sts_clr;
   // target access monitor
   logic tgt_active;
   logic [CMD_W-1:0] tgt_cmd;
   // pins
   logic m66en;
   logic [3:0] req_n;

   modport dev (
      input reg_req, reg_we, reg_addr, reg_wdata,
      output reg_rdata, reg_ack,
      input pm_state_wr, pme_en_set, pme_sts_clr, tgt_active, tgt_cmd, m66en, req_n
   );
   modport host (
      output reg_req, reg_we, reg_addr, reg_wdata,
      input reg_rdata, reg_ack,
      output pm_state_wr, pme_en_set, pme_sts_clr, tgt_active, tgt_cmd, m66en, req_n
   );
endinterface
`default_nettype wire

// [core/pxm_port_route.sv]
// Purpose: picks the request source for one arbiter port
// Assumes: requests are active high and already synchronised
// Notes: reserved codes select nothing
`default_nettype none
module pxm_port_route
   import pxm_pkg::*;
(
   // selection
   input wire logic [SEL_W-1:0] sel,
   // sources
   input wire logic ctrl_req,
   input wire logic [3:0] ext_req,
   // result
   output logic port_req
);
   always_comb begin
      if (sel == SRC_CTRL) begin
         port_req = ctrl_req;
      end else if (sel >= SRC_RSV_LO) begin
         port_req = 1'b0;
      end else begin
         port_req = ext_req[sel[1:0]];
      end
   end
endmodule
`default_nettype wire

// [core/pxm_dev.sv]
// Purpose: event mask, target command monitor and request port map
// Assumes: far end drives event pulses on mclk; m66en and req_n are pins
// Notes: map_changed pulses on every port map write
`default_nettype none
module pxm_dev
   import pxm_pkg::*;
(
   // clock and reset
   input wire logic mclk,
   input wire logic rst,
   // link
   pxm_if.dev lnk,
   // controller side
   input wire logic host_mode,
   input wire logic ctrl_req,
   output logic [NPORT-1:0] arb_req,
   output logic map_changed,
   output logic irq
);
   typedef struct packed {
      logic [3:0] ien;
      logic [2:0] flg;
      logic [CMD_W-1:0] cmd;
      logic [NPORT-1:0][SEL_W-1:0] map;
      logic [DATA_W-1:0] rdata;
      logic ack;
      logic irq;
      logic [1:0] m66_s;
      logic [3:0] req_s1;
      logic [3:0] req_s2;
      logic [NPORT-1:0] arb;
      logic map_chg;
   } pxm_dev_st_t;

   pxm_dev_st_t st_q;
   pxm_dev_st_t st_d;
   logic [NPORT-1:0] route;
   logic wr;
   logic rd;
   logic [2:0] ev;
   logic [3:0] pend;
   logic fast_lvl;
   // address decode for writes
   logic hit_status;
   logic hit_ien;
   logic hit_map;
   // per-port map fields and read words
   logic [NPORT-1:0][SEL_W-1:0] map_wr;
   logic [NPORT-1:0][DATA_W-1:0] map_rd;
   logic [DATA_W-1:0] map_word;
   logic [DATA_W-1:0] status_word;
   logic [DATA_W-1:0] ien_word;
   logic [DATA_W-1:0] cmd_word;

   // one router and one map field per port
   genvar gi;
   generate
      for (gi = 0; gi < NPORT; gi = gi + 1) begin : g_port
         // field position of this port: A, B, C from the top down
         localparam int LO = (gi == 0) ? PORT_A_LO : ((gi == 1) ? PORT_B_LO : PORT_C_LO);
         // field written and read back in place
         assign map_wr[gi] = lnk.reg_wdata[LO +: SEL_W];
         assign map_rd[gi] = DATA_W'(st_q.map[gi]) << LO;
         pxm_port_route u_route (
            .sel(st_q.map[gi]),
            .ctrl_req(ctrl_req),
            .ext_req(~st_q.req_s2),
            .port_req(route[gi])
         );
      end
   endgenerate

   always_comb begin
      st_d = st_q;
      wr = lnk.reg_req & lnk.reg_we;
      rd = lnk.reg_req & ~lnk.reg_we;
      fast_lvl = st_q.m66_s[1];
      ev = {lnk.pm_state_wr, lnk.pme_en_set, lnk.pme_sts_clr};
      hit_status = (lnk.reg_addr == OFF_STATUS);
      hit_ien = (lnk.reg_addr == OFF_IRQ_EN);
      hit_map = (lnk.reg_addr == OFF_PORT_MAP);

      // pins pass two flops before use
      // only the second stage is read, so no metastable bit spreads
      st_d.m66_s = {st_q.m66_s[0], lnk.m66en};
      st_d.req_s1 = lnk.req_n;
      st_d.req_s2 = st_q.req_s1;

      if (wr && hit_status) begin
         st_d.flg = st_q.flg & ~lnk.reg_wdata[EV_HI:BIT_WAKE_CLR];
      end
      st_d.flg = st_d.flg | ev;

      if (wr && hit_ien) begin
         st_d.ien = lnk.reg_wdata[EV_HI:EV_LO];
      end

      st_d.map_chg = 1'b0;
      if (wr && hit_map) begin
         st_d.map = map_wr;
         st_d.map_chg = 1'b1;
      end

      // command of access in progress
      // sampled each clock: a command shorter than a clock is missed
      st_d.cmd = lnk.tgt_active ? lnk.tgt_cmd : RST_CMD;

      // read words: reserved bits stay zero
      status_word = '0;
      status_word[EV_HI:BIT_WAKE_CLR] = st_q.flg;
      status_word[BIT_FAST] = fast_lvl;
      ien_word = '0;
      ien_word[EV_HI:EV_LO] = st_q.ien;
      cmd_word = '0;
      cmd_word[CMD_LO +: CMD_W] = st_q.cmd;
      map_word = '0;
      for (int i = 0; i < NPORT; i++) begin
         map_word = map_word | map_rd[i];
      end

      // unmapped reads give zero
      // writes are answered too, so the far end never waits on a bad address
      st_d.ack = lnk.reg_req;
      st_d.rdata = '0;
      if (rd) begin
         case (lnk.reg_addr)
            OFF_STATUS: begin
               st_d.rdata = status_word;
            end
            OFF_IRQ_EN: begin
               st_d.rdata = ien_word;
            end
            OFF_TGT_CMD: begin
               st_d.rdata = cmd_word;
            end
            OFF_PORT_MAP: begin
               st_d.rdata = map_word;
            end
            default: begin
               st_d.rdata = '0;
            end
         endcase
      end

      pend[3:1] = st_q.flg & st_q.ien[3:1];
      // fast bus term only as satellite
      // status cannot clear; enable masks it
      pend[0] = fast_lvl & st_q.ien[0] & ~host_mode;
      // any pending event
      // registered, so enable writes never glitch the pin
      st_d.irq = |pend;

      st_d.arb = route;
   end

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         st_q.ien <= RST_IRQ_EN;
         st_q.flg <= RST_FLAGS;
         st_q.cmd <= RST_CMD;
         st_q.map[0] <= RST_PORT_A;
         st_q.map[1] <= RST_PORT_B;
         st_q.map[2] <= RST_PORT_C;
         st_q.rdata <= '0;
         st_q.ack <= 1'b0;
         st_q.irq <= 1'b0;
         st_q.m66_s <= 2'h0;
         // pins idle high (no request)
         st_q.req_s1 <= 4'hf;
         st_q.req_s2 <= 4'hf;
         st_q.arb <= '0;
         st_q.map_chg <= 1'b0;
      end else begin
         st_q <= st_d;
      end
   end

   assign lnk.reg_rdata = st_q.rdata;
   assign lnk.reg_ack = st_q.ack;
   assign arb_req = st_q.arb;
   assign map_changed = st_q.map_chg;
   assign irq = st_q.irq;
endmodule
`default_nettype wire

// [core/pxm_host.sv]
// Purpose: far party: issues register accesses, drives events and pins
// Assumes: one access outstanding at a time
// Notes: port map writes with clashing live codes are refused locally
`default_nettype none
module pxm_host
   import pxm_pkg::*;
(
   // clock and reset
   input wire logic mclk,
   input wire logic rst,
   // link
   pxm_if.host lnk,
   // command port
   input wire logic cmd_valid,
   input wire logic cmd_write,
   input wire logic [ADDR_W-1:0] cmd_addr,
   input wire logic [DATA_W-1:0] cmd_wdata,
   input wire logic fast_mask_req,
   output logic cmd_ready,
   output logic rsp_valid,
   output logic [DATA_W-1:0] rsp_rdata,
   output logic rsp_err,
   output logic map_changed,
   // bus side events and pins
   input wire logic pm_state_write,
   input wire logic pme_en_write_set,
   input wire logic pme_status_cleared,
   input wire logic target_active,
   input wire logic [CMD_W-1:0] target_cmd,
   input wire logic bus_66mhz,
   input wire logic [3:0] ext_req
);
   typedef enum logic [0:0] {PXM_IDLE, PXM_WAIT} pxm_hstate_t;
   typedef struct packed {
      pxm_hstate_t state;
      logic req;
      logic we;
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
      logic [3:0] ien_shadow;
      logic rsp_valid;
      logic [DATA_W-1:0] rsp_rdata;
      logic rsp_err;
      logic map_chg;
      logic [2:0] ev;
      logic tgt_active;
      logic [CMD_W-1:0] tgt_cmd;
      logic m66en;
      logic [3:0] req_n;
   } pxm_host_st_t;

   pxm_host_st_t st_q;
   pxm_host_st_t st_d;
   logic [2:0] f [3];
   logic clash;

   always_comb begin
      st_d = st_q;
      f[0] = cmd_wdata[PORT_A_LO +: SEL_W];
      f[1] = cmd_wdata[PORT_B_LO +: SEL_W];
      f[2] = cmd_wdata[PORT_C_LO +: SEL_W];
      // live codes must differ; unused ones are reserved
      clash = (f[0] < SRC_RSV_LO || f[0] == SRC_CTRL) && f[0] == f[1] ||
              (f[0] < SRC_RSV_LO || f[0] == SRC_CTRL) && f[0] == f[2] ||
              (f[1] < SRC_RSV_LO || f[1] == SRC_CTRL) && f[1] == f[2];
      st_d.req = 1'b0;
      st_d.rsp_valid = 1'b0;
      st_d.rsp_err = 1'b0;
      st_d.map_chg = 1'b0;
      st_d.ev = {pm_state_write, pme_en_write_set, pme_status_cleared};
      st_d.tgt_active = target_active;
      st_d.tgt_cmd = target_cmd;
      st_d.m66en = bus_66mhz;
      st_d.req_n = ~ext_req;
      case (st_q.state)
         PXM_IDLE: begin
            if (cmd_valid) begin
               if (cmd_write && cmd_addr == OFF_PORT_MAP && clash) begin
                  st_d.rsp_valid = 1'b1;
                  st_d.rsp_err = 1'b1;
                  st_d.rsp_rdata = '0;
               end else begin
                  st_d.req = 1'b1;
                  st_d.we = cmd_write;
                  st_d.addr = cmd_addr;
                  st_d.wdata = cmd_wdata;
                  st_d.state = PXM_WAIT;
                  if (cmd_write && cmd_addr == OFF_IRQ_EN) begin
                     st_d.ien_shadow = cmd_wdata[EV_HI:EV_LO];
                  end
                  if (cmd_write && cmd_addr == OFF_PORT_MAP) begin
                     st_d.map_chg = 1'b1;
                  end
               end
            end else if (fast_mask_req) begin
               st_d.req = 1'b1;
               st_d.we = 1'b1;
               st_d.addr = OFF_IRQ_EN;
               st_d.wdata = '0;
               st_d.wdata[EV_HI:BIT_WAKE_CLR] = st_q.ien_shadow[3:1];
               st_d.ien_shadow[0] = 1'b0;
               st_d.state = PXM_WAIT;
            end
         end
         PXM_WAIT: begin
            if (lnk.reg_ack) begin
               st_d.rsp_valid = 1'b1;
               st_d.rsp_rdata = lnk.reg_rdata;
               st_d.state = PXM_IDLE;
            end
         end
         default: begin
            st_d.state = PXM_IDLE;
         end
      endcase
   end

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         st_q.state <= PXM_IDLE;
         st_q.req <= 1'b0;
         st_q.we <= 1'b0;
         st_q.addr <= '0;
         st_q.wdata <= '0;
         st_q.ien_shadow <= RST_IRQ_EN;
         st_q.rsp_valid <= 1'b0;
         st_q.rsp_rdata <= '0;
         st_q.rsp_err <= 1'b0;
         st_q.map_chg <= 1'b0;
         st_q.ev <= 3'h0;
         st_q.tgt_active <= 1'b0;
         st_q.tgt_cmd <= RST_CMD;
         st_q.m66en <= 1'b0;
         st_q.req_n <= 4'hf;
      end else begin
         st_q <= st_d;
      end
   end

   assign cmd_ready = (st_q.state == PXM_IDLE);
   assign rsp_valid = st_q.rsp_valid;
   assign rsp_rdata = st_q.rsp_rdata;
   assign rsp_err = st_q.rsp_err;
   assign map_changed = st_q.map_chg;
   assign lnk.reg_req = st_q.req;
   assign lnk.reg_we = st_q.we;
   assign lnk.reg_addr = st_q.addr;
   assign lnk.reg_wdata = st_q.wdata;
   assign lnk.pm_state_wr = st_q.ev[2];
   assign lnk.pme_en_set = st_q.ev[1];
   assign lnk.pme_sts_clr = st_q.ev[0];
   assign lnk.tgt_active = st_q.tgt_active;
   assign lnk.tgt_cmd = st_q.tgt_cmd;
   assign lnk.m66en = st_q.m66en;
   assign lnk.req_n = st_q.req_n;
endmodule
`default_nettype wire

// [bench/pxm_assertions.sv]
// Purpose: concurrent checks on the register link and the dev outputs
// Assumes: one clock mclk; rst asynchronous, active high
// Notes: enable shadow is rebuilt from writes seen on the link
`default_nettype none
module pxm_assertions
   import pxm_pkg::*;
(
   // clock and reset
   input wire logic mclk,
   input wire logic rst,
   // register link
   input wire logic reg_req,
   input wire logic reg_we,
   input wire logic [ADDR_W-1:0] reg_addr,
   input wire logic [DATA_W-1:0] reg_wdata,
   input wire logic [DATA_W-1:0] reg_rdata,
   input wire logic reg_ack,
   input wire logic m66en,
   // dev side
   input wire logic host_mode,
   input wire logic map_changed,
   input wire logic irq,
   // host side
   input wire logic host_map_changed
);
   logic [3:0] en_q;

   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (rst);

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         en_q <= 4'h0;
      end else if (reg_req && reg_we && reg_addr == OFF_IRQ_EN) begin
         en_q <= reg_wdata[EV_HI:EV_LO];
      end
   end

   sequence s_rd(logic [15:0] a);
      reg_req && !reg_we && reg_addr == a;
   endsequence
   sequence s_wr_map;
      reg_req && reg_we && reg_addr == OFF_PORT_MAP;
   endsequence
   // fast term counts only outside host mode
   sequence s_quiet;
      en_q[3:1] == 3'h0 && !(en_q[0] && !host_mode);
   endsequence

   chk_ack_one_later: assert property (reg_req |=> reg_ack)
      else $error("no answer one cycle after request");
   chk_ack_has_cause: assert property (reg_ack |-> $past(reg_req))
      else $error("answer without request");
   chk_rdata_idle_zero: assert property (!reg_ack |-> reg_rdata == 32'h0)
      else $error("read data not zero outside answer");
   chk_mask_readback: assert property (
      s_rd(OFF_IRQ_EN) |=> reg_rdata == {7'h0, $past(en_q), 21'h0})
      else $error("mask read differs from written enables");
   chk_cmd_rsv_zero: assert property (s_rd(OFF_TGT_CMD) |=> reg_rdata[31:4] == 28'h0)
      else $error("command register upper bits not zero");
   chk_map_rsv_zero: assert property (
      s_rd(OFF_PORT_MAP) |=> (reg_rdata & 32'h888f_ffff) == 32'h0)
      else $error("port map reserved bits not zero");
   chk_status_rsv_zero: assert property (
      s_rd(OFF_STATUS) |=> (reg_rdata & 32'hfe1f_ffff) == 32'h0)
      else $error("status reserved bits not zero");
   chk_fast_level: assert property (
      $stable(m66en)[*4] ##0 s_rd(OFF_STATUS) |=> reg_rdata[BIT_FAST] == $past(m66en))
      else $error("status fast bit differs from pin");
   chk_map_pulse: assert property (s_wr_map |=> map_changed)
      else $error("no map change pulse after map write");
   chk_pulse_cause: assert property (
      map_changed |-> $past(reg_req && reg_we && reg_addr == OFF_PORT_MAP))
      else $error("map change pulse without map write");
   chk_irq_quiet: assert property (s_quiet[*4] |-> !irq)
      else $error("interrupt raised with no live enable");
   chk_host_map_lead: assert property (host_map_changed |=> map_changed)
      else $error("host map change not followed by dev pulse");
endmodule
`default_nettype wire

// [bench/tb_top.sv]
// Purpose: drives both ends through the host command port and checks outputs
// Assumes: mclk 100 MHz; inputs change 1 ns after the rising edge
// Notes: clash refusal is judged on the host response
`default_nettype none
`define PXM_CHK(nm, e, g) begin total_checks++; if ((g) !== (e)) begin n_mismatch++; \
   $display("MISMATCH %s expected %h seen %h", nm, e, g); end end
module tb_top
   import pxm_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic mclk = 1'h0, rst = 1'h1, host_mode = 1'h1, ctrl_req = 1'h0;
   logic cmd_valid = 1'h0, cmd_write = 1'h0, fast_mask_req = 1'h0, m66 = 1'h0, tact = 1'h0;
   logic [15:0] cmd_addr = 16'h0;
   logic [31:0] cmd_wdata = 32'h0, rd, map, rsp_rdata;
   logic [2:0] ev = 3'h0, arb_req;
   logic [3:0] tcmd = 4'h0, ext = 4'h0;
   logic [4:0] src;
   logic cmd_ready, rsp_valid, rsp_err, er, map_changed, irq, host_map_chg;
   int n_mismatch = 0, total_checks = 0, cyc = 0;

   pxm_if lnk ();
   pxm_dev pxm_dev_inst (.mclk(mclk), .rst(rst), .lnk(lnk.dev), .host_mode(host_mode),
      .ctrl_req(ctrl_req), .arb_req(arb_req), .map_changed(map_changed), .irq(irq));
   pxm_host pxm_host_inst (.mclk(mclk), .rst(rst), .lnk(lnk.host), .cmd_valid(cmd_valid),
      .cmd_write(cmd_write), .cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata),
      .fast_mask_req(fast_mask_req), .cmd_ready(cmd_ready), .rsp_valid(rsp_valid),
      .rsp_rdata(rsp_rdata), .rsp_err(rsp_err), .map_changed(host_map_chg),
      .pm_state_write(ev[0]),
      .pme_en_write_set(ev[1]), .pme_status_cleared(ev[2]), .target_active(tact),
      .target_cmd(tcmd), .bus_66mhz(m66), .ext_req(ext));
   pxm_assertions pxm_assertions_inst (.mclk(mclk), .rst(rst), .reg_req(lnk.reg_req),
      .reg_we(lnk.reg_we), .reg_addr(lnk.reg_addr), .reg_wdata(lnk.reg_wdata),
      .reg_rdata(lnk.reg_rdata), .reg_ack(lnk.reg_ack), .m66en(lnk.m66en),
      .host_mode(host_mode), .map_changed(map_changed), .irq(irq),
      .host_map_changed(host_map_chg));

   always #5 mclk = ~mclk;

   task automatic test_done;
      $display("checks %0d mismatches %0d", total_checks, n_mismatch);
      if (n_mismatch == 0 && total_checks > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask

   // whole run is well under 2000 cycles
   always @(posedge mclk) begin
      cyc++;
      if (cyc == 5000) begin
         n_mismatch++;
         test_done();
      end
   end

   task automatic tick(input int n);
      repeat (n) @(posedge mclk);
      #1;
   endtask

   task automatic acc(input logic w, input logic [15:0] a, input logic [31:0] d);
      int n = 0;
      cmd_write = w;
      cmd_addr = a;
      cmd_wdata = d;
      cmd_valid = 1'h1;
      tick(1);
      cmd_valid = 1'h0;
      while (rsp_valid !== 1'h1 && n < 20) begin
         tick(1);
         n++;
      end
      if (n == 20) begin
         n_mismatch++;
      end
      rd = rsp_rdata;
      er = rsp_err;
   endtask

   task automatic rdchk(input logic [15:0] a, input logic [31:0] e);
      acc(1'h0, a, 32'h0);
      `PXM_CHK($sformatf("read %h", a), e, rd)
   endtask

   initial begin
      tick(3);
      rst = 1'h0;
      rdchk(OFF_IRQ_EN, 32'h0);
      rdchk(OFF_TGT_CMD, 32'h0);
      rdchk(OFF_PORT_MAP, 32'h7650_0000);
      rdchk(OFF_STATUS, 32'h0);
      acc(1'h1, OFF_IRQ_EN, 32'hffff_ffff);
      rdchk(OFF_IRQ_EN, 32'h01e0_0000);
      acc(1'h1, OFF_IRQ_EN, 32'h0);
      host_mode = 1'h0;
      for (int i = 0; i < 3; i++) begin
         ev[i] = 1'h1;
         tick(1);
         ev[i] = 1'h0;
         tick(4);
         `PXM_CHK("irq masked", 1'h0, irq)
         rdchk(OFF_STATUS, 32'h1 << (BIT_PSTATE - i));
         acc(1'h1, OFF_IRQ_EN, 32'h1 << (BIT_PSTATE - i));
         tick(2);
         `PXM_CHK("irq enabled", 1'h1, irq)
         acc(1'h1, OFF_STATUS, 32'h1 << (BIT_PSTATE - i));
         tick(2);
         `PXM_CHK("irq cleared", 1'h0, irq)
         acc(1'h1, OFF_IRQ_EN, 32'h0);
      end
      host_mode = 1'h1;
      m66 = 1'h1;
      acc(1'h1, OFF_IRQ_EN, 32'h0020_0000);
      tick(4);
      `PXM_CHK("irq host mode", 1'h0, irq)
      rdchk(OFF_STATUS, 32'h0020_0000);
      host_mode = 1'h0;
      tick(2);
      `PXM_CHK("irq satellite", 1'h1, irq)
      acc(1'h1, OFF_STATUS, 32'h0020_0000);
      rdchk(OFF_STATUS, 32'h0020_0000);
      fast_mask_req = 1'h1;
      tick(1);
      fast_mask_req = 1'h0;
      tick(6);
      `PXM_CHK("irq after mask", 1'h0, irq)
      m66 = 1'h0;
      tact = 1'h1;
      tcmd = 4'ha;
      tick(3);
      rdchk(OFF_TGT_CMD, 32'ha);
      acc(1'h1, OFF_TGT_CMD, 32'hffff_ffff);
      rdchk(OFF_TGT_CMD, 32'ha);
      tact = 1'h0;
      tick(3);
      rdchk(OFF_TGT_CMD, 32'h0);
      // every code on every port, the other ports parked on a reserved code
      for (int p = 0; p < 3; p++) begin
         for (int c = 0; c < 8; c++) begin
            map = 32'h4440_0000;
            map[PORT_A_LO - 4 * p +: 3] = c[2:0];
            acc(1'h1, OFF_PORT_MAP, map | 32'h888f_ffff);
            `PXM_CHK("map write taken", 1'h0, er)
            rdchk(OFF_PORT_MAP, map);
            src = (c > 3 && c < 7) ? 5'h1f : 5'h1 << (c == 7 ? 4 : c);
            {ctrl_req, ext} = src;
            tick(5);
            `PXM_CHK("route on", (c > 3 && c < 7) ? 3'h0 : 3'h1 << p, arb_req)
            {ctrl_req, ext} = ~src;
            tick(5);
            `PXM_CHK("route others", 3'h0, arb_req)
         end
      end
      acc(1'h1, OFF_PORT_MAP, 32'h0);
      `PXM_CHK("clash refused", 1'h1, er)
      `PXM_CHK("ready after refusal", 1'h1, cmd_ready)
      rdchk(OFF_PORT_MAP, map);
      test_done();
   end
endmodule
`default_nettype wire
